// ===== fpac_pkg.sv
package fpac_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_STATUS1 = 8'h00;
	localparam logic [7:0] OFF_CONTROL1 = 8'h04;
	localparam logic [7:0] OFF_FCWIN = 8'h08;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFF_MEMTEST = 8'h14;
	localparam logic [7:0] OFF_EVCOUNT = 8'h18;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ST_BUSY = 2;
	localparam int ST_CHAIN_BUSY = 3;
	localparam int ST_DATA_READY = 0;
	localparam int ST_MEB_FULL = 1;
	localparam int CT_RESET_TYPE = 4;
	localparam int IRQ_W = 4;
	localparam int IRQ_GATE = 0;
	localparam int IRQ_CONV_DONE = 1;
	localparam int IRQ_FCLEAR = 2;
	localparam int IRQ_FPRESET = 3;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] CONTROL1_RST = 32'h0000_0000;
	localparam logic [9:0] FCWIN_RST = 10'h010;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 100;
	localparam int CONV_NS = 2800;
	localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
	localparam int ARESET_NS = 600;
	localparam int ARESET_CYC = (ARESET_NS + CLK_NS - 1) / CLK_NS;
	localparam int CONFIG_NS = 100000;
	localparam int CONFIG_CYC = (CONFIG_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACK_LED_NS = 1000;
	localparam int ACK_LED_CYC = ACK_LED_NS / CLK_NS;
	localparam int MEB_DEPTH = 32;

	typedef struct packed {
		logic window;
		logic fast_clear;
		logic reset;
		logic inhibit;
	} fpac_fp_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_ARESET = 2'b11
	} fpac_state_t;
endpackage

// ===== fpac_sync.sv
`timescale 1ns/1ns
module fpac_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] rise
);
	logic [W-1:0] meta;
	logic [W-1:0] last;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
			last <= '0;
		end else begin
			meta <= d;
			q <= meta;
			last <= q;
		end
	end

	assign rise = q & ~last;
endmodule

// ===== fpac_axil.sv
`timescale 1ns/1ns
module fpac_axil (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic rd_en,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok,
	input wire logic wr_ok
);
	logic aw_held;
	logic w_held;

	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign arready = !rvalid;
	assign wr_en = aw_held && w_held && !bvalid;
	assign rd_en = arvalid && arready;
	assign rd_addr = araddr;

	// Address and data may arrive in either order
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				wr_addr <= awaddr;
			end else if (wr_en) begin
				aw_held <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end else if (wr_en) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bvalid <= 1'b0;
			bresp <= 2'b00;
		end else if (wr_en) begin
			bvalid <= 1'b1;
			bresp <= wr_ok ? 2'b00 : 2'b10;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'b00;
		end else if (rd_en) begin
			rvalid <= 1'b1;
			rdata <= rd_ok ? rd_data : 32'h0000_0000;
			rresp <= rd_ok ? 2'b00 : 2'b10;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule

// ===== fpac_top.sv
`timescale 1ns/1ns
// Function
// - Fast clear in window aborts conversion
// - Panel reset clears peaks, store, conversion
// - Reset type selects control register clear
// - Inhibit input blocks conversion
// - Busy when converting, resetting, testing, full
// - Own busy in status bit 2
// - Chain busy wired OR and NOR
// - Chain busy line in status bit 3
// - Peaks detected only inside gate window
// - Access indicator pulses on bus access
// - Data ready while store holds events
// - Busy and ready lit at power on
// - Option high: halt on any chain busy
// - Option low: halt on own busy only
// - Fast clear window opens at gate edge
// - Gate ignored while busy
// - Reset type bit: data or software
module fpac_top #(
	parameter int CONFIG_CYCLES = fpac_pkg::CONFIG_CYC,
	parameter int MEB_DEPTH = fpac_pkg::MEB_DEPTH
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Front panel inputs
	input wire logic ACQUISITION_WINDOW_INPUT,
	input wire logic FAST_CLEAR_INPUT,
	input wire logic RESET_INPUT,
	input wire logic CONVERSION_INHIBIT_INPUT,
	// Chain busy lines, open drain
	input wire logic CHAIN_BUSY_P_IN,
	output logic CHAIN_BUSY_P_OE,
	input wire logic CHAIN_BUSY_N_IN,
	output logic CHAIN_BUSY_N_OE,
	// Outputs and indicators
	output logic BUSY_OUT,
	output logic BUSY_INDICATOR,
	output logic DATA_READY_INDICATOR,
	output logic BUS_ACCESS_INDICATOR,
	output logic PEAK_CLEAR,
	output logic PEAK_ENABLE,
	// Board option
	input wire logic BUSY_SCOPE_OPTION,
	// Store interface
	input wire logic MULTI_EVENT_STORE_READ,
	output logic [5:0] MULTI_EVENT_STORE_COUNT,
	// AXI4-Lite slave
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// Interrupt
	output logic IRQ
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int IRQ_W_L = fpac_pkg::IRQ_W;

	fpac_pkg::fpac_fp_t fp_raw;
	fpac_pkg::fpac_fp_t fp_lvl;
	fpac_pkg::fpac_fp_t fp_edge;
	logic [1:0] chain_lvl;
	fpac_pkg::fpac_state_t state;
	fpac_pkg::fpac_state_t next_state;
	logic [11:0] timer;
	logic [9:0] fc_timer;
	logic fc_window;
	logic [31:0] control1;
	logic [9:0] fc_win_len;
	logic memtest;
	logic [IRQ_W_L-1:0] irq_status;
	logic [IRQ_W_L-1:0] irq_mask;
	logic [IRQ_W_L-1:0] irq_event;
	logic [23:0] ev_count;
	logic [5:0] meb_count;
	logic meb_full;
	logic own_busy;
	logic halt;
	logic [$clog2(fpac_pkg::CONFIG_CYC+1)+6:0] cfg_cnt;
	logic configuring;
	logic [7:0] ack_cnt;
	logic wr_en;
	logic rd_en;
	logic [7:0] wr_addr;
	logic [7:0] rd_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] rd_data;
	logic rd_ok;
	logic wr_ok;
	logic gate_take;
	logic fclear_take;
	logic conv_done;
	logic sw_reset;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == fpac_pkg::OFF_STATUS1) || (a == fpac_pkg::OFF_CONTROL1)
			|| (a == fpac_pkg::OFF_FCWIN) || (a == fpac_pkg::OFF_IRQ_STATUS)
			|| (a == fpac_pkg::OFF_IRQ_MASK) || (a == fpac_pkg::OFF_MEMTEST)
			|| (a == fpac_pkg::OFF_EVCOUNT);
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	assign fp_raw = '{window: ACQUISITION_WINDOW_INPUT, fast_clear: FAST_CLEAR_INPUT,
		reset: RESET_INPUT, inhibit: CONVERSION_INHIBIT_INPUT};

	fpac_sync #(.W(4)) u_fp_sync (
		.clk(MCLK),
		.rst(SYS_RST),
		.d(fp_raw),
		.q(fp_lvl),
		.rise(fp_edge)
	);

	fpac_sync #(.W(2)) u_chain_sync (
		.clk(MCLK),
		.rst(SYS_RST),
		.d({CHAIN_BUSY_P_IN, CHAIN_BUSY_N_IN}),
		.q(chain_lvl),
		.rise()
	);

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	fpac_axil u_bus (
		.clk(MCLK),
		.rst(SYS_RST),
		.awaddr(AWADDR),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.wdata(WDATA),
		.wstrb(WSTRB),
		.wvalid(WVALID),
		.wready(WREADY),
		.bresp(BRESP),
		.bvalid(BVALID),
		.bready(BREADY),
		.araddr(ARADDR),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.rdata(RDATA),
		.rresp(RRESP),
		.rvalid(RVALID),
		.rready(RREADY),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok),
		.wr_ok(wr_ok)
	);

	assign rd_ok = mapped(rd_addr);
	assign wr_ok = mapped(wr_addr);

	// ----------------------------------------
	// Busy and halt
	// ----------------------------------------
	assign meb_full = (meb_count == 6'(MEB_DEPTH));
	assign own_busy = (state != fpac_pkg::ST_IDLE) || memtest || meb_full;
	// Option high waits on the whole chain, low on this board alone
	assign halt = BUSY_SCOPE_OPTION ? (own_busy || chain_lvl[1]) : own_busy;
	assign gate_take = fp_edge.window && !halt;
	assign fclear_take = fp_edge.fast_clear && fc_window;
	assign sw_reset = fp_edge.reset && control1[fpac_pkg::CT_RESET_TYPE];
	assign conv_done = (state == fpac_pkg::ST_CONV) && (timer == 12'h000) && !fp_lvl.inhibit;

	// Open drain: P line pulled high when any board drives, N pulled low
	assign CHAIN_BUSY_P_OE = own_busy;
	assign CHAIN_BUSY_N_OE = own_busy;
	assign BUSY_OUT = own_busy;
	assign BUSY_INDICATOR = own_busy || configuring;
	assign DATA_READY_INDICATOR = (meb_count != 6'h00) || configuring;
	assign BUS_ACCESS_INDICATOR = (ack_cnt != 8'h00);
	assign PEAK_ENABLE = fp_lvl.window && !halt;
	assign MULTI_EVENT_STORE_COUNT = meb_count;
	assign IRQ = |(irq_status & irq_mask);

	// ----------------------------------------
	// Conversion sequence
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			fpac_pkg::ST_IDLE: begin
				if (gate_take) begin
					next_state = fpac_pkg::ST_CONV;
				end
			end
			fpac_pkg::ST_CONV: begin
				if (fclear_take || fp_edge.reset) begin
					next_state = fpac_pkg::ST_ARESET;
				end else if (conv_done) begin
					next_state = fpac_pkg::ST_ARESET;
				end
			end
			fpac_pkg::ST_ARESET: begin
				if (timer == 12'h000) begin
					next_state = fpac_pkg::ST_IDLE;
				end
			end
			default: next_state = fpac_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state <= fpac_pkg::ST_IDLE;
			timer <= 12'h000;
		end else begin
			state <= next_state;
			if (state != next_state && next_state == fpac_pkg::ST_CONV) begin
				timer <= 12'(fpac_pkg::CONV_CYC - 1);
			end else if (state != next_state && next_state == fpac_pkg::ST_ARESET) begin
				timer <= 12'(fpac_pkg::ARESET_CYC - 1);
			end else if (timer != 12'h000) begin
				timer <= timer - 12'h001;
			end
		end
	end

	// Inhibit holds the conversion at its last step, so peaks are not digitised until it drops
	assign PEAK_CLEAR = (state == fpac_pkg::ST_ARESET) || fp_edge.reset;

	// ----------------------------------------
	// Fast clear window
	// ----------------------------------------
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			fc_window <= 1'b0;
			fc_timer <= 10'h000;
		end else if (gate_take) begin
			fc_window <= 1'b1;
			fc_timer <= fc_win_len;
		end else if (fc_timer != 10'h000) begin
			fc_timer <= fc_timer - 10'h001;
		end else begin
			fc_window <= 1'b0;
		end
	end

	// ----------------------------------------
	// Event store occupancy and counter
	// ----------------------------------------
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			meb_count <= 6'h00;
			ev_count <= 24'h000000;
		end else if (fp_edge.reset) begin
			meb_count <= 6'h00;
			ev_count <= 24'h000000;
		end else begin
			if (conv_done && !MULTI_EVENT_STORE_READ) begin
				meb_count <= meb_count + 6'h01;
			end else if (!conv_done && MULTI_EVENT_STORE_READ && meb_count != 6'h00) begin
				meb_count <= meb_count - 6'h01;
			end
			if (gate_take) begin
				ev_count <= ev_count + 24'h000001;
			end
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			control1 <= fpac_pkg::CONTROL1_RST;
			fc_win_len <= fpac_pkg::FCWIN_RST;
			memtest <= 1'b0;
			irq_mask <= fpac_pkg::IRQ_MASK_RST;
		end else if (sw_reset) begin
			control1 <= fpac_pkg::CONTROL1_RST;
			fc_win_len <= fpac_pkg::FCWIN_RST;
			memtest <= 1'b0;
			irq_mask <= fpac_pkg::IRQ_MASK_RST;
		end else if (wr_en && wr_strb[0]) begin
			case (wr_addr)
				fpac_pkg::OFF_CONTROL1: control1 <= {24'h000000, wr_data[7:0]};
				fpac_pkg::OFF_FCWIN: fc_win_len <= {fc_win_len[9:8], wr_data[7:0]};
				fpac_pkg::OFF_MEMTEST: memtest <= wr_data[0];
				fpac_pkg::OFF_IRQ_MASK: irq_mask <= wr_data[IRQ_W_L-1:0];
				default: ;
			endcase
			if (wr_addr == fpac_pkg::OFF_FCWIN && wr_strb[1]) begin
				fc_win_len[9:8] <= wr_data[9:8];
			end
		end else if (wr_en && wr_strb[1] && wr_addr == fpac_pkg::OFF_FCWIN) begin
			fc_win_len[9:8] <= wr_data[9:8];
		end
	end

	// ----------------------------------------
	// Interrupt status, write one to clear
	// ----------------------------------------
	assign irq_event = {fp_edge.reset, fclear_take && (state == fpac_pkg::ST_CONV),
		conv_done, gate_take};

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_status <= '0;
		end else if (wr_en && wr_strb[0] && wr_addr == fpac_pkg::OFF_IRQ_STATUS) begin
			irq_status <= (irq_status & ~wr_data[IRQ_W_L-1:0]) | irq_event;
		end else begin
			irq_status <= irq_status | irq_event;
		end
	end

	// ----------------------------------------
	// Indicators
	// ----------------------------------------
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cfg_cnt <= '0;
			configuring <= 1'b1;
		end else if (configuring) begin
			if (cfg_cnt == ($bits(cfg_cnt))'(CONFIG_CYCLES - 1)) begin
				configuring <= 1'b0;
			end
			cfg_cnt <= cfg_cnt + 1'b1;
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ack_cnt <= 8'h00;
		end else if (wr_en || rd_en) begin
			ack_cnt <= 8'(fpac_pkg::ACK_LED_CYC);
		end else if (ack_cnt != 8'h00) begin
			ack_cnt <= ack_cnt - 8'h01;
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		rd_data = 32'h0000_0000;
		case (rd_addr)
			fpac_pkg::OFF_STATUS1: begin
				rd_data[fpac_pkg::ST_DATA_READY] = (meb_count != 6'h00);
				rd_data[fpac_pkg::ST_MEB_FULL] = meb_full;
				rd_data[fpac_pkg::ST_BUSY] = own_busy;
				rd_data[fpac_pkg::ST_CHAIN_BUSY] = chain_lvl[1];
			end
			fpac_pkg::OFF_CONTROL1: rd_data = control1;
			fpac_pkg::OFF_FCWIN: rd_data = {22'h000000, fc_win_len};
			fpac_pkg::OFF_IRQ_STATUS: rd_data = {28'h0000000, irq_status};
			fpac_pkg::OFF_IRQ_MASK: rd_data = {28'h0000000, irq_mask};
			fpac_pkg::OFF_MEMTEST: rd_data = {31'h00000000, memtest};
			fpac_pkg::OFF_EVCOUNT: rd_data = {8'h00, ev_count};
			default: rd_data = 32'h0000_0000;
		endcase
	end
endmodule

// ===== fpac_top_chk.sv
`timescale 1ns/1ns
module fpac_top_chk (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Panel and option
	input wire logic ACQUISITION_WINDOW_INPUT,
	input wire logic FAST_CLEAR_INPUT,
	input wire logic RESET_INPUT,
	input wire logic CONVERSION_INHIBIT_INPUT,
	input wire logic BUSY_SCOPE_OPTION,
	// Chain
	input wire logic CHAIN_BUSY_P_IN,
	input wire logic CHAIN_BUSY_P_OE,
	input wire logic CHAIN_BUSY_N_OE,
	// Outputs
	input wire logic BUSY_OUT,
	input wire logic BUSY_INDICATOR,
	input wire logic DATA_READY_INDICATOR,
	input wire logic BUS_ACCESS_INDICATOR,
	input wire logic PEAK_CLEAR,
	input wire logic PEAK_ENABLE,
	input wire logic [5:0] MULTI_EVENT_STORE_COUNT,
	// Read address handshake
	input wire logic ARVALID,
	input wire logic ARREADY
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	property p_chain; CHAIN_BUSY_P_OE == BUSY_OUT && CHAIN_BUSY_N_OE == BUSY_OUT; endproperty
	a_chain: assert property (p_chain) else $error("chain drive differs from busy");
	property p_lamp; BUSY_OUT |-> BUSY_INDICATOR; endproperty
	a_lamp: assert property (p_lamp) else $error("busy lamp dark while busy");
	property p_ready; MULTI_EVENT_STORE_COUNT != 6'h00 |-> DATA_READY_INDICATOR; endproperty
	a_ready: assert property (p_ready) else $error("ready lamp dark with events");
	property p_access; ARVALID && ARREADY |-> ##[0:1] BUS_ACCESS_INDICATOR [*8]; endproperty
	a_access: assert property (p_access) else $error("access lamp too short");
	property p_one;
		MULTI_EVENT_STORE_COUNT > $past(MULTI_EVENT_STORE_COUNT) |->
			BUSY_OUT && MULTI_EVENT_STORE_COUNT == $past(MULTI_EVENT_STORE_COUNT) + 6'h01;
	endproperty
	a_one: assert property (p_one) else $error("store grew outside one conversion");
	property p_inhibit;
		CONVERSION_INHIBIT_INPUT [*4] |-> MULTI_EVENT_STORE_COUNT <= $past(MULTI_EVENT_STORE_COUNT);
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("event stored while inhibited");
	property p_own; BUSY_OUT [*2] |-> !PEAK_ENABLE; endproperty
	a_own: assert property (p_own) else $error("peaks enabled while busy");
	property p_ext; (BUSY_SCOPE_OPTION && CHAIN_BUSY_P_IN) [*4] |-> !PEAK_ENABLE; endproperty
	a_ext: assert property (p_ext) else $error("peaks enabled while chain busy");
	property p_window; !ACQUISITION_WINDOW_INPUT [*4] |-> !PEAK_ENABLE; endproperty
	a_window: assert property (p_window) else $error("peaks enabled outside window");
	property p_panel; $rose(RESET_INPUT) |-> ##[1:4] PEAK_CLEAR; endproperty
	a_panel: assert property (p_panel) else $error("panel reset left peaks");
	// Window of at least ten cycles is kept by the bench
	sequence s_open; !BUSY_OUT && !CHAIN_BUSY_P_IN && $rose(ACQUISITION_WINDOW_INPUT); endsequence
	sequence s_inside; s_open ##5 $rose(FAST_CLEAR_INPUT); endsequence
	property p_clear; s_inside |-> ##[1:5] PEAK_CLEAR; endproperty
	a_clear: assert property (p_clear) else $error("fast clear in window ignored");
endmodule

bind fpac_top fpac_top_chk chk_u (.MCLK(MCLK), .SYS_RST(SYS_RST),
	.ACQUISITION_WINDOW_INPUT(ACQUISITION_WINDOW_INPUT), .FAST_CLEAR_INPUT(FAST_CLEAR_INPUT),
	.RESET_INPUT(RESET_INPUT), .CONVERSION_INHIBIT_INPUT(CONVERSION_INHIBIT_INPUT),
	.BUSY_SCOPE_OPTION(BUSY_SCOPE_OPTION), .CHAIN_BUSY_P_IN(CHAIN_BUSY_P_IN),
	.CHAIN_BUSY_P_OE(CHAIN_BUSY_P_OE), .CHAIN_BUSY_N_OE(CHAIN_BUSY_N_OE), .BUSY_OUT(BUSY_OUT),
	.BUSY_INDICATOR(BUSY_INDICATOR), .DATA_READY_INDICATOR(DATA_READY_INDICATOR),
	.BUS_ACCESS_INDICATOR(BUS_ACCESS_INDICATOR), .PEAK_CLEAR(PEAK_CLEAR),
	.PEAK_ENABLE(PEAK_ENABLE), .MULTI_EVENT_STORE_COUNT(MULTI_EVENT_STORE_COUNT),
	.ARVALID(ARVALID), .ARREADY(ARREADY));

// ===== fpac_far.sv
`timescale 1ns/1ns
module fpac_far (
	// Clock
	input wire logic clk,
	// Requests from the bench
	input wire logic [3:0] fire,
	input wire logic hold_inhibit,
	input wire logic other_busy,
	// Own drive of the chain
	input wire logic own_p_oe,
	input wire logic own_n_oe,
	// Lines seen by the block
	output fpac_pkg::fpac_fp_t fp,
	output logic chain_p,
	output logic chain_n
);
	// Three cycles per pulse, far above the minimum width
	logic [3:0][1:0] left = '0;
	always @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (fire[i]) begin
				left[i] <= 2'h3;
			end else if (left[i] != 2'h0) begin
				left[i] <= left[i] - 2'h1;
			end
		end
	end
	// Field order: window, fast clear, reset, inhibit
	assign fp = {left[3] != 2'h0, left[2] != 2'h0, left[1] != 2'h0,
		left[0] != 2'h0 || hold_inhibit};
	// Released lines rest at their pull levels
	assign chain_p = own_p_oe || other_busy;
	assign chain_n = !(own_n_oe || other_busy);
endmodule

// ===== fpac_tb.sv
`timescale 1ns/1ns
module tb;
	localparam int G = 3;
	localparam int FC = 2;
	localparam int RS = 1;
	logic MCLK, SYS_RST, hold_inh, other_busy, opt, store_rd;
	logic [3:0] fire, wstrb;
	fpac_pkg::fpac_fp_t fp;
	logic cp_in, cn_in, cp_oe, cn_oe, busy, busy_led, rdy_led, acc_led, pclr, pen, irq;
	logic [5:0] cnt;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	logic [33:0] q_rd[$];
	logic [1:0] q_b[$];
	int fail_count, tests_run;

	fpac_top #(.CONFIG_CYCLES(5), .MEB_DEPTH(4)) dut_u (.MCLK(MCLK), .SYS_RST(SYS_RST),
		.ACQUISITION_WINDOW_INPUT(fp.window), .FAST_CLEAR_INPUT(fp.fast_clear),
		.RESET_INPUT(fp.reset), .CONVERSION_INHIBIT_INPUT(fp.inhibit),
		.CHAIN_BUSY_P_IN(cp_in), .CHAIN_BUSY_P_OE(cp_oe), .CHAIN_BUSY_N_IN(cn_in),
		.CHAIN_BUSY_N_OE(cn_oe), .BUSY_OUT(busy), .BUSY_INDICATOR(busy_led),
		.DATA_READY_INDICATOR(rdy_led), .BUS_ACCESS_INDICATOR(acc_led), .PEAK_CLEAR(pclr),
		.PEAK_ENABLE(pen), .BUSY_SCOPE_OPTION(opt), .MULTI_EVENT_STORE_READ(store_rd),
		.MULTI_EVENT_STORE_COUNT(cnt), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.IRQ(irq));
	fpac_far far_u (.clk(MCLK), .fire(fire), .hold_inhibit(hold_inh), .other_busy(other_busy),
		.own_p_oe(cp_oe), .own_n_oe(cn_oe), .fp(fp), .chain_p(cp_in), .chain_n(cn_in));

	initial begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end

	task automatic test_done();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic lvl(input string n, input logic e, input logic g);
		cmp(n, {33'h0, e}, {33'h0, g});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK);
	endtask
	task automatic pulse(input int i);
		fire[i] <= 1'b1;
		@(posedge MCLK);
		fire <= 4'h0;
	endtask
	task automatic drain();
		store_rd <= 1'b1;
		@(posedge MCLK);
		store_rd <= 1'b0;
		cyc(3);
	endtask
	// Sync, conversion and analog reset all fit in forty cycles
	task automatic conv();
		pulse(G);
		cyc(40);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		bit ao, wo;
		q_b.push_back(e);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		{awvalid, wvalid, bready} <= 3'h7;
		{ao, wo} = 2'h0;
		while (!(ao && wo)) begin
			@(posedge MCLK);
			if (awready && !ao) awvalid <= 1'b0;
			if (wready && !wo) wvalid <= 1'b0;
			ao |= awready;
			wo |= wready;
		end
		do @(posedge MCLK); while (!bvalid);
		bready <= 1'b0;
		@(posedge MCLK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		q_rd.push_back({e, d});
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(posedge MCLK); while (!arready);
		arvalid <= 1'b0;
		do @(posedge MCLK); while (!rvalid);
		rready <= 1'b0;
		@(posedge MCLK);
	endtask
	task automatic t_end(input string n);
		$display("test %s finished", n);
	endtask

	always @(posedge MCLK) begin
		if (rvalid && rready) cmp("read data and response", q_rd.pop_front(), {rresp, rdata});
		if (bvalid && bready) cmp("write response", {32'h0, q_b.pop_front()}, {32'h0, bresp});
	end

	// Whole run is under a thousand cycles
	initial begin
		#(20000 * 100);
		fail_count++;
		test_done();
	end

	initial begin
		{fail_count, tests_run} = '0;
		{hold_inh, other_busy, opt, store_rd, fire, wstrb, awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		SYS_RST = 1'b1;
		v = $urandom(32'h561a);
		cyc(2);
		SYS_RST <= 1'b0;
		cyc(2);
		lvl("config busy lamp", 1'b1, busy_led);
		lvl("config ready lamp", 1'b1, rdy_led);
		cyc(8);
		lvl("busy lamp", 1'b0, busy_led);
		lvl("ready lamp", 1'b0, rdy_led);
		t_end("power on");
		rd(fpac_pkg::OFF_CONTROL1, 32'h0, 2'h0);
		rd(fpac_pkg::OFF_FCWIN, 32'h10, 2'h0);
		rd(fpac_pkg::OFF_IRQ_MASK, 32'h0, 2'h0);
		rd(8'h40, 32'h0, 2'h2);
		wr(8'h40, 32'h1, 2'h2);
		v = 32'ha + ($urandom % 20);
		wr(fpac_pkg::OFF_FCWIN, v, 2'h0);
		rd(fpac_pkg::OFF_FCWIN, v, 2'h0);
		lvl("access lamp", 1'b1, acc_led);
		t_end("registers");
		pulse(G);
		cyc(8);
		rd(fpac_pkg::OFF_STATUS1, 32'hc, 2'h0);
		pulse(G);
		cyc(40);
		cmp("events", 34'h1, {28'h0, cnt});
		lvl("ready lamp", 1'b1, rdy_led);
		rd(fpac_pkg::OFF_STATUS1, 32'h1, 2'h0);
		rd(fpac_pkg::OFF_IRQ_STATUS, 32'h3, 2'h0);
		lvl("irq masked", 1'b0, irq);
		wr(fpac_pkg::OFF_IRQ_MASK, 32'h2, 2'h0);
		cyc(2);
		lvl("irq", 1'b1, irq);
		wr(fpac_pkg::OFF_IRQ_STATUS, 32'h2, 2'h0);
		cyc(2);
		lvl("irq cleared", 1'b0, irq);
		rd(fpac_pkg::OFF_EVCOUNT, 32'h1, 2'h0);
		drain();
		lvl("ready lamp", 1'b0, rdy_led);
		t_end("conversion");
		hold_inh <= 1'b1;
		conv();
		lvl("busy inhibited", 1'b1, busy);
		cmp("events", 34'h0, {28'h0, cnt});
		hold_inh <= 1'b0;
		cyc(40);
		cmp("events", 34'h1, {28'h0, cnt});
		drain();
		t_end("inhibit");
		wr(fpac_pkg::OFF_IRQ_STATUS, 32'hf, 2'h0);
		pulse(G);
		cyc(4);
		pulse(FC);
		cyc(40);
		cmp("events", 34'h0, {28'h0, cnt});
		rd(fpac_pkg::OFF_IRQ_STATUS, 32'h5, 2'h0);
		pulse(FC);
		repeat (6) begin
			@(posedge MCLK);
			lvl("stray clear", 1'b0, pclr);
		end
		t_end("fast clear");
		conv();
		pulse(G);
		cyc(6);
		wr(fpac_pkg::OFF_FCWIN, 32'h20, 2'h0);
		pulse(RS);
		cyc(12);
		lvl("busy", 1'b0, busy);
		cmp("events", 34'h0, {28'h0, cnt});
		rd(fpac_pkg::OFF_FCWIN, 32'h20, 2'h0);
		conv();
		wr(fpac_pkg::OFF_CONTROL1, 32'h10, 2'h0);
		pulse(RS);
		cyc(12);
		cmp("events", 34'h0, {28'h0, cnt});
		rd(fpac_pkg::OFF_CONTROL1, 32'h0, 2'h0);
		rd(fpac_pkg::OFF_FCWIN, 32'h10, 2'h0);
		rd(fpac_pkg::OFF_IRQ_STATUS, 32'hf, 2'h0);
		t_end("panel reset");
		wr(fpac_pkg::OFF_MEMTEST, 32'h1, 2'h0);
		cyc(2);
		lvl("memtest busy", 1'b1, busy);
		wr(fpac_pkg::OFF_MEMTEST, 32'h0, 2'h0);
		cyc(2);
		lvl("memtest busy", 1'b0, busy);
		repeat (4) conv();
		lvl("full busy", 1'b1, busy);
		rd(fpac_pkg::OFF_STATUS1, 32'hf, 2'h0);
		drain();
		lvl("full busy", 1'b0, busy);
		repeat (3) drain();
		t_end("busy sources");
		{opt, other_busy} <= 2'h3;
		cyc(2);
		rd(fpac_pkg::OFF_STATUS1, 32'h8, 2'h0);
		pulse(G);
		cyc(3);
		lvl("peak enable", 1'b0, pen);
		cyc(40);
		opt <= 1'b0;
		pulse(G);
		cyc(3);
		lvl("own scope peak enable", 1'b1, pen);
		cyc(3);
		lvl("own scope busy", 1'b1, busy);
		cyc(40);
		other_busy <= 1'b0;
		t_end("busy scope");
		test_done();
	end
endmodule
